// [logic/rtcac_top.sv]
// Alarm and control register logic of the calendar unit
// Summary of operation
// - Bit 31 enables alarm event generation.
// - Chime set lets repeat count wrap.
// - Chime clear holds repeat count at zero.
// - Interval codes zero to four select.
// - Codes five to nine; leap-day yearly.
// - Repeat field counts remaining repetitions.
// - Zero count with chime clear means last alarm.
// - Each alarm event but the last decrements counter.
// - Enable bit gates all counting.
// - Lock clear needs unlock sequence.
// - Clear, set, invert aliases per register.
// - Unused bits read zero; reset zero.
// - Lock blocks timekeeping register writes.
// - Output pin shows selected signal.
`timescale 1ns/1ps
module rtcac_top
   import rtcac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  busAddr,
   input  wire logic        busWrite,
   input  wire logic        busRead,
   input  wire logic [31:0] busWdata,
   output logic [31:0]      busRdata,
   input  wire logic        unlocked,
   input  wire logic [31:0] timeNow,
   input  wire logic [31:0] dateNow,
   input  wire logic        halfTick,
   input  wire logic        secTick,
   input  wire logic        srcClkPin,
   output logic             alarmEvent,
   output logic             alarmUpdatePending,
   output logic             unitCountEnable,
   output logic             timeWriteStrobe,
   output logic             dateWriteStrobe,
   output logic [31:0]      timeWriteData,
   output logic [31:0]      dateWriteData,
   output logic             clockOutPin
);
   logic [31:0]  rtc_control_one;
   logic [31:0]  alarm_time_compare;
   logic [31:0]  alarm_date_compare;
   logic [31:0]  next_ctrl;
   logic [31:0]  next_atime;
   logic [31:0]  next_adate;
   logic         srcSync;
   logic         secHold;
   logic         matchHit;
   logic         fireNow;
   rtcac_state_t state;
   rtcac_state_t next_state;

   // Register decode: low two bits of the word index select alias
   logic [1:0] aliasOp;
   logic [7:0] baseAddr;
   logic       selCtrl;
   logic       selTime;
   logic       selDate;
   logic       selAtime;
   logic       selAdate;
   logic       lockWin;
   assign aliasOp  = busAddr[3:2];
   assign baseAddr = {busAddr[7:4], 4'h0};
   assign selCtrl  = (baseAddr == RTCAC_OFS_CTRL);
   assign selTime  = (baseAddr == RTCAC_OFS_TIME);
   assign selDate  = (baseAddr == RTCAC_OFS_DATE);
   assign selAtime = (baseAddr == RTCAC_OFS_ATIME);
   assign selAdate = (baseAddr == RTCAC_OFS_ADATE);

   // Alias merge of written ones as a mask
   function automatic logic [31:0] rtcac_merge(input logic [31:0] cur,
                                               input logic [31:0] wd,
                                               input logic [1:0]  al,
                                               input logic [31:0] msk);
      logic [31:0] r;
      r = cur;
      if (al == RTCAC_ALIAS_WR) begin
         r = wd;
      end else if (al == RTCAC_ALIAS_CLR) begin
         r = cur & ~wd;
      end else if (al == RTCAC_ALIAS_SET) begin
         r = cur | wd;
      end else begin
         r = cur ^ wd;
      end
      return r & msk;
   endfunction : rtcac_merge

   // Alarm compare and source clock pin crossing
   rtcac_match u_match (
      .interval  (rtc_control_one[RTCAC_B_MSKL+3:RTCAC_B_MSKL]),
      .timeNow   (timeNow),
      .dateNow   (dateNow),
      .timeAlarm (alarm_time_compare),
      .dateAlarm (alarm_date_compare),
      .halfTick  (halfTick),
      .secTick   (secTick),
      .hit       (matchHit)
   );
   rtcac_sync u_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  (srcClkPin),
      .dout (srcSync)
   );

   assign fireNow = rtc_control_one[RTCAC_B_ALMEN] && rtc_control_one[RTCAC_B_ON] && matchHit;

   // Proposed control value from software
   logic [31:0] swCtrl;
   logic [31:0] ctrlWr;
   logic        lockClrBad;
   assign swCtrl = rtcac_merge(rtc_control_one, busWdata, aliasOp, RTCAC_CTRL_MASK);
   assign lockClrBad = rtc_control_one[RTCAC_B_LOCK] && !swCtrl[RTCAC_B_LOCK] && !unlocked;
   assign ctrlWr = lockClrBad ? (swCtrl | (32'h00000001 << RTCAC_B_LOCK)) : swCtrl;
   assign lockWin = busWrite && !rtc_control_one[RTCAC_B_LOCK];

   // Repeat counter step and alarm enable clear after last alarm
   logic [7:0]  rpt;
   logic [7:0]  rptNext;
   logic        chime;
   logic [31:0] ctrlPre;
   // Idle bus data must not leak into the count; only a real write does
   assign ctrlPre = (busWrite && selCtrl) ? ctrlWr : rtc_control_one;
   assign rpt   = ctrlPre[RTCAC_B_RPTL+7:RTCAC_B_RPTL];
   assign chime = rtc_control_one[RTCAC_B_CHIME];
   // decrement per event; wrap; hold at zero
   assign rptNext = (rpt != 8'h00 || chime) ? rpt - 8'h01 : 8'h00;

   // Control next value: software write first, then alarm bookkeeping
   always_comb begin
      next_ctrl = rtc_control_one;
      if (busWrite && selCtrl) begin
         next_ctrl = ctrlWr;
      end
      if (fireNow) begin
         next_ctrl[RTCAC_B_RPTL+7:RTCAC_B_RPTL] = rptNext;
         if (rpt == 8'h00 && !chime) begin
            next_ctrl[RTCAC_B_ALMEN] = 1'b0;
         end
      end
   end

   // Alarm compare registers follow lock as well
   assign next_atime = (lockWin && selAtime) ?
                       rtcac_merge(alarm_time_compare, busWdata, aliasOp, RTCAC_TIME_MASK) :
                       alarm_time_compare;
   assign next_adate = (lockWin && selAdate) ?
                       rtcac_merge(alarm_date_compare, busWdata, aliasOp, RTCAC_DATE_MASK) :
                       alarm_date_compare;

   // Update pending sequencer: marks the alarm-side bookkeeping cycle
   always_comb begin
      next_state = state;
      case (state)
         RTCAC_IDLE: if (fireNow) next_state = RTCAC_ARM;
         RTCAC_ARM:  next_state = RTCAC_POST;
         RTCAC_POST: next_state = RTCAC_IDLE;
         default:    next_state = RTCAC_IDLE;
      endcase
   end

   // Read mux; unmapped words read zero
   logic [31:0] rdSel;
   assign rdSel = (selCtrl && aliasOp == RTCAC_ALIAS_WR)  ? rtc_control_one :
                  (selAtime && aliasOp == RTCAC_ALIAS_WR) ? alarm_time_compare :
                  (selAdate && aliasOp == RTCAC_ALIAS_WR) ? alarm_date_compare :
                  32'h00000000;

   logic pinSel;
   assign pinSel = !rtc_control_one[RTCAC_B_OE] ? 1'b0 :
      (rtc_control_one[RTCAC_B_SELL+2:RTCAC_B_SELL] == RTCAC_SEL_ALARM) ? fireNow :
      (rtc_control_one[RTCAC_B_SELL+2:RTCAC_B_SELL] == RTCAC_SEL_SEC)   ? secHold :
      (rtc_control_one[RTCAC_B_SELL+2:RTCAC_B_SELL] == RTCAC_SEL_SRC)   ? srcSync :
      1'b0;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rtc_control_one    <= RTCAC_CTRL_RESET;
         alarm_time_compare <= 32'h00000000;
         alarm_date_compare <= 32'h00000000;
         state              <= RTCAC_IDLE;
      end else begin
         rtc_control_one    <= next_ctrl;
         alarm_time_compare <= next_atime;
         alarm_date_compare <= next_adate;
         state              <= next_state;
      end
   end

   // Seconds square wave toggles on each half-second tick while the unit runs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         secHold <= 1'b0;
      end else if (halfTick && rtc_control_one[RTCAC_B_ON]) begin
         secHold <= ~secHold;
      end
   end

   // Registered outputs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         busRdata           <= 32'h00000000;
         alarmEvent         <= 1'b0;
         alarmUpdatePending <= 1'b0;
         unitCountEnable    <= 1'b0;
         timeWriteStrobe    <= 1'b0;
         dateWriteStrobe    <= 1'b0;
         timeWriteData      <= 32'h00000000;
         dateWriteData      <= 32'h00000000;
         clockOutPin        <= 1'b0;
      end else begin
         busRdata           <= busRead ? rdSel : 32'h00000000;
         alarmEvent         <= fireNow;
         alarmUpdatePending <= fireNow || (state != RTCAC_IDLE);
         unitCountEnable    <= next_ctrl[RTCAC_B_ON];
         timeWriteStrobe    <= lockWin && selTime;
         dateWriteStrobe    <= lockWin && selDate;
         timeWriteData      <= rtcac_merge(timeNow, busWdata, aliasOp, RTCAC_TIME_MASK);
         dateWriteData      <= rtcac_merge(dateNow, busWdata, aliasOp, RTCAC_DATE_MASK);
         clockOutPin        <= pinSel;
      end
   end
endmodule : rtcac_top

// [logic/rtcac_pkg.sv]
// Constants for the alarm and control portion of the calendar unit
package rtcac_pkg;
   // Register byte offsets and alias word index (byte address = index times four)
   localparam logic [7:0] RTCAC_OFS_CTRL  = 8'h00;
   localparam logic [7:0] RTCAC_OFS_TIME  = 8'h20;
   localparam logic [7:0] RTCAC_OFS_DATE  = 8'h30;
   localparam logic [7:0] RTCAC_OFS_ATIME = 8'h50;
   localparam logic [7:0] RTCAC_OFS_ADATE = 8'h60;
   localparam logic [1:0] RTCAC_ALIAS_WR  = 2'h0;
   localparam logic [1:0] RTCAC_ALIAS_CLR = 2'h1;
   localparam logic [1:0] RTCAC_ALIAS_SET = 2'h2;
   localparam logic [1:0] RTCAC_ALIAS_INV = 2'h3;
   // Control field positions
   localparam int RTCAC_B_ALMEN = 31;
   localparam int RTCAC_B_CHIME = 30;
   localparam int RTCAC_B_MSKL  = 24;
   localparam int RTCAC_B_RPTL  = 16;
   localparam int RTCAC_B_ON    = 15;
   localparam int RTCAC_B_LOCK  = 11;
   localparam int RTCAC_B_OE    = 7;
   localparam int RTCAC_B_SELL  = 4;
   // Writable bits; all others read zero
   localparam logic [31:0] RTCAC_CTRL_MASK  = 32'hcfff88f0;
   localparam logic [31:0] RTCAC_CTRL_RESET = 32'h00000000;
   // Time word: hour[29:24] minute[22:16] second[15:8]; date: year[31:24] month[20:16]
   // day[13:8] weekday[2:0]
   localparam logic [31:0] RTCAC_TIME_MASK = 32'h3f7fff00;
   localparam logic [31:0] RTCAC_DATE_MASK = 32'hff1f3f07;
   // Interval codes
   localparam logic [3:0] RTCAC_I_HALF = 4'h0;
   localparam logic [3:0] RTCAC_I_SEC  = 4'h1;
   localparam logic [3:0] RTCAC_I_S10  = 4'h2;
   localparam logic [3:0] RTCAC_I_MIN  = 4'h3;
   localparam logic [3:0] RTCAC_I_M10  = 4'h4;
   localparam logic [3:0] RTCAC_I_HOUR = 4'h5;
   localparam logic [3:0] RTCAC_I_DAY  = 4'h6;
   localparam logic [3:0] RTCAC_I_WEEK = 4'h7;
   localparam logic [3:0] RTCAC_I_MON  = 4'h8;
   localparam logic [3:0] RTCAC_I_YEAR = 4'h9;
   // Clock output selections
   localparam logic [2:0] RTCAC_SEL_ALARM = 3'h0;
   localparam logic [2:0] RTCAC_SEL_SEC   = 3'h1;
   localparam logic [2:0] RTCAC_SEL_SRC   = 3'h2;
   // Update pending state machine
   typedef enum logic [2:0] {
      RTCAC_IDLE = 3'b001,
      RTCAC_ARM  = 3'b010,
      RTCAC_POST = 3'b100
   } rtcac_state_t;
endpackage : rtcac_pkg

// [logic/rtcac_sync.sv]
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module rtcac_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic din,
   output logic      dout
);
   logic stage1;
   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rstn) begin
         stage1 <= 1'b0;
         dout   <= 1'b0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule : rtcac_sync

// [logic/rtcac_match.sv]
// Alarm compare of the time and date words under the interval mask
`timescale 1ns/1ps
module rtcac_match
   import rtcac_pkg::*;
(
   input  wire logic [3:0]  interval,
   input  wire logic [31:0] timeNow,
   input  wire logic [31:0] dateNow,
   input  wire logic [31:0] timeAlarm,
   input  wire logic [31:0] dateAlarm,
   input  wire logic        halfTick,
   input  wire logic        secTick,
   output logic             hit
);
   logic [31:0] tMask;
   logic [31:0] dMask;
   logic        tick;
   logic        valid;
   // interval field decode
   // Coarser intervals compare more fields; finer digits always compared
   always_comb begin
      tMask = 32'h00000000;
      dMask = 32'h00000000;
      valid = 1'b1;
      case (interval)
         RTCAC_I_HALF: tMask = 32'h00000000;
         RTCAC_I_SEC:  tMask = 32'h00000000;
         RTCAC_I_S10:  tMask = 32'h00000f00;
         RTCAC_I_MIN:  tMask = 32'h00007f00;
         RTCAC_I_M10:  tMask = 32'h000f7f00;
         RTCAC_I_HOUR: tMask = 32'h007f7f00;
         RTCAC_I_DAY:  tMask = RTCAC_TIME_MASK;
         RTCAC_I_WEEK: begin
            tMask = RTCAC_TIME_MASK;
            dMask = 32'h00000007;
         end
         RTCAC_I_MON: begin
            tMask = RTCAC_TIME_MASK;
            dMask = 32'h00003f00;
         end
         // Feb 29 naturally matches only in leap years
         RTCAC_I_YEAR: begin
            tMask = RTCAC_TIME_MASK;
            dMask = 32'h001f3f00;
         end
         default: valid = 1'b0;
      endcase
   end
   assign tick = (interval == RTCAC_I_HALF) ? halfTick : secTick;
   assign hit  = valid && tick && (((timeNow ^ timeAlarm) & tMask) == 32'h00000000)
                 && (((dateNow ^ dateAlarm) & dMask) == 32'h00000000);
endmodule : rtcac_match

// [tb/rtcac_top_asserts.sv]
// Port-level assertions for the calendar alarm and control block
`timescale 1ns/1ps
module rtcac_top_asserts (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  busAddr,
   input wire logic        busWrite,
   input wire logic        busRead,
   input wire logic [31:0] busWdata,
   input wire logic [31:0] busRdata,
   input wire logic        halfTick,
   input wire logic        secTick,
   input wire logic        alarmEvent,
   input wire logic        alarmUpdatePending,
   input wire logic        unitCountEnable,
   input wire logic        timeWriteStrobe,
   input wire logic        clockOutPin
);
   // Single domain; reset silences every check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Read data only in the cycle after a read, unused bits always low
   idle_read_zero_a: assert property (!$past(busRead) |-> busRdata == 32'h0)
      else $error("read data outside read");
   unused_bits_a: assert property ($past(busRead) && $past(busAddr) == 8'h00
      |-> (busRdata & 32'h3000770f) == 32'h0) else $error("unused bit set");
   alias_read_a: assert property ($past(busRead) && $past(busAddr[3:0]) != 4'h0
      |-> busRdata == 32'h0) else $error("alias read not zero");
   // Enable bit reaches the counters in the same cycle as the register
   enable_set_a: assert property (busWrite && busAddr == 8'h08 && busWdata[15]
      |-> ##2 unitCountEnable) else $error("enable not set");
   enable_clear_a: assert property (busWrite && busAddr == 8'h04 && busWdata[15]
      |-> ##2 !unitCountEnable) else $error("enable not cleared");
   pin_off_a: assert property (busWrite && busAddr == 8'h04 && busWdata[7]
      |-> ##3 !clockOutPin) else $error("pin driven while off");
   // Events need a tick and a running unit, and keep pending up three cycles
   event_cause_a: assert property (alarmEvent |-> $past(secTick || halfTick))
      else $error("event without tick");
   event_enabled_a: assert property (alarmEvent |-> $past(unitCountEnable))
      else $error("event while stopped");
   pending_hold_a: assert property (alarmEvent |-> alarmUpdatePending [*3])
      else $error("pending too short");
   time_strobe_a: assert property (timeWriteStrobe |-> $past(busAddr[7:4]) == 4'h2)
      else $error("stray time strobe");
   // Main scenarios reached
   cover property (alarmEvent);
   cover property (timeWriteStrobe);
   cover property (clockOutPin);
endmodule : rtcac_top_asserts

bind rtcac_top rtcac_top_asserts i_rtcac_top_asserts (.clk, .rstn, .busAddr, .busWrite,
   .busRead, .busWdata, .busRdata, .halfTick, .secTick, .alarmEvent, .alarmUpdatePending,
   .unitCountEnable, .timeWriteStrobe, .clockOutPin);

// [tb/tb_top.sv]
// Self-checking bench for the calendar alarm and control block
`timescale 1ns/1ps
module tb_top;
   logic        clk, rstn, busWrite, busRead, unlocked, halfTick, secTick, srcClkPin;
   logic        alarmEvent, alarmUpdatePending, unitCountEnable, timeWriteStrobe;
   logic        dateWriteStrobe, clockOutPin;
   logic [7:0]  busAddr;
   logic [31:0] busWdata, timeNow, dateNow, busRdata, rd, model, d;
   int          n_mismatch, check_count, cycles, evCount, wsCount, seed, i;

   rtcac_top i_rtcac_top (.clk, .rstn, .busAddr, .busWrite, .busRead, .busWdata, .busRdata,
      .unlocked, .timeNow, .dateNow, .halfTick, .secTick, .srcClkPin, .alarmEvent,
      .alarmUpdatePending, .unitCountEnable, .timeWriteStrobe, .dateWriteStrobe,
      .timeWriteData(), .dateWriteData(), .clockOutPin);

   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Tally events and accepted time and date writes; the ceiling cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (alarmEvent === 1'b1) evCount <= evCount + 1;
      if (timeWriteStrobe === 1'b1 || dateWriteStrobe === 1'b1) wsCount <= wsCount + 1;
      if (cycles == 4000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Bus cycles; a spare edge keeps strobes from being driven twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      busAddr <= a;
      busWdata <= v;
      busWrite <= 1'b1;
      @(posedge clk);
      busWrite <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge clk);
      busRead <= 1'b0;
      #1 rd = busRdata;
      @(posedge clk);
   endtask : rdr
   // Expected control word after a plain, clear, set or invert write
   function automatic logic [31:0] expCtrl(input logic [31:0] c, input int al,
                                           input logic [31:0] v);
      return (al == 0 ? v : al == 1 ? c & ~v : al == 2 ? c | v : c ^ v) & 32'hcfff88f0;
   endfunction : expCtrl
   // no write until pending closes
   // One tick, then room for the pending window to close
   task automatic tick(input logic half);
      halfTick <= half;
      secTick <= ~half;
      @(posedge clk);
      halfTick <= 1'b0;
      secTick <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : tick
   // Optional control write, one tick, then control word and event tally
   task automatic step(input logic [31:0] w, input logic half, input logic [31:0] e,
                       input int n);
      if (w !== 32'h0) wr(8'h00, w);
      tick(half);
      rdr(8'h00);
      chk("alarm ctrl", rd, e);
      chk("events", 32'(evCount), 32'(n));
   endtask : step
   // Pin settles through the synchroniser before it is looked at
   task automatic look(input string what, input logic e);
      repeat (6) @(posedge clk);
      #1 chk(what, 32'(clockOutPin), 32'(e));
      @(posedge clk);
   endtask : look
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   // Reset, then the scenarios in order
   initial begin
      seed = 16055;
      {rstn, busWrite, busRead, unlocked, halfTick, secTick, srcClkPin} = 7'h00;
      {busAddr, busWdata, timeNow, dateNow} = 104'h0;
      n_mismatch = 0;
      check_count = 0;
      cycles = 0;
      evCount = 0;
      wsCount = 0;
      model = 32'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdr(8'h00);
      chk("ctrl reset", rd, 32'h0);
      // every alias, all ones first, then random masks
      unlocked <= 1'b1;
      for (i = 0; i < 40; i++) begin
         d = (i == 0) ? 32'hffffffff : $random(seed);
         wr({4'h0, 2'(i % 4), 2'b00}, d);
         model = expCtrl(model, i % 4, d);
         rdr(8'h00);
         chk("ctrl alias", rd, model);
      end
      // lock refuses its own clear and timekeeping writes
      wr(8'h00, 32'h00000800);
      unlocked <= 1'b0;
      wr(8'h04, 32'h00000800);
      wr(8'h20, 32'h01020304);
      wr(8'h30, 32'h01020304);
      rdr(8'h00);
      chk("lock kept", rd, 32'h00000800);
      chk("locked writes", 32'(wsCount), 32'h0);
      unlocked <= 1'b1;
      wr(8'h04, 32'h00000800);
      wr(8'h20, 32'h01020304);
      wr(8'h30, 32'h01020304);
      rdr(8'h00);
      chk("lock freed", rd, 32'h0);
      chk("open writes", 32'(wsCount), 32'h2);
      // count down, stop at zero, disabled paths
      step(32'h81018000, 1'b0, 32'h81008000, 1);
      step(32'h0, 1'b0, 32'h01008000, 2);
      step(32'h0, 1'b0, 32'h01008000, 2);
      step(32'hc1050000, 1'b0, 32'hc1050000, 2);
      // every interval code, counter wraps with chime set
      for (i = 0; i < 10; i++) begin
         d = 32'hc0008000 | (32'(i) << 24);
         step(d, i == 0, d | 32'h00ff0000, i + 3);
      end
      // source select follows the pin; disabled and reserved give zero
      wr(8'h00, 32'h000000a0);
      srcClkPin <= 1'b1;
      look("pin source", 1'b1);
      wr(8'h04, 32'h00000080);
      look("pin off", 1'b0);
      wr(8'h00, 32'h000000b0);
      look("pin reserved", 1'b0);
      // alias and unmapped reads return zero
      rdr(8'h08);
      chk("alias read", rd, 32'h0);
      rdr(8'h70);
      chk("unmapped read", rd, 32'h0);
      test_done();
   end
endmodule : tb_top
